// *** hw/lrsc_pkg.sv ***
// Package for the load-reserve / store-conditional reservation block.
// Assumes 32-bit instruction words with bit 31 as the most significant bit in the encoding.
package lrsc_pkg;
	// ----------------------------------------
	// Instruction encoding
	// ----------------------------------------
	localparam logic [5:0] OPC_LOAD = 6'h32;
	localparam logic [5:0] OPC_STORE = 6'h36;
	localparam logic [10:0] FN_RESERVE_LOAD = 11'h400;
	localparam logic [10:0] FN_COND_STORE = 11'h200;
	localparam int OPC_HI = 31;
	localparam int OPC_LO = 26;
	localparam int RD_HI = 25;
	localparam int RD_LO = 21;
	localparam int FN_HI = 10;
	localparam int FN_LO = 0;
	localparam logic [1:0] WORD_ALIGN = 2'h0;
	localparam logic [3:0] ALL_LANES = 4'hF;
	localparam logic RESV_RESET = 1'b0;
	localparam logic CARRY_SUCCESS = 1'b0;
	localparam logic CARRY_FAIL = 1'b1;

	typedef enum logic [1:0] {
		LRSC_IDLE,
		LRSC_LOAD,
		LRSC_STORE
	} lrsc_state_t;
endpackage : lrsc_pkg

// *** hw/lrsc_reservation.sv ***
// Reservation logic for reserving loads and conditional stores.
// Assumes the pipeline presents one instruction with its three source operands and
// holds it until done; the data memory answers with memAck.
//
// Behaviour
// - Reserving load fetches the word into the destination and sets the reservation.
// - Conditional store with reservation writes memory and clears carry.
// - Conditional store without reservation writes nothing and sets carry.
// - Word granularity; address forced aligned; never raises an unaligned fault.
// - Store attempted whenever reserved, with no address comparison.
// - Only one reservation; a later reserving load replaces its address.
// - Every conditional store clears the reservation.
// - Reset, interrupt, exception and break all clear the reservation.
// - Other masters may read while reserved; no lock is asserted.
// - Reserving load decode: opcode 110010, function 10000000000, address Ra plus Rb.
// - Conditional store decode: opcode 110110, function 1000000000, written only if reserved.
`timescale 1ns/1ps
module lrsc_reservation #(
	parameter int ADDR_W = 32,
	parameter int DATA_W = 32
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic instValid,
	input wire logic [31:0] instWord,
	input wire logic [DATA_W-1:0] srcA,
	input wire logic [DATA_W-1:0] srcB,
	input wire logic [DATA_W-1:0] srcStore,
	input wire logic takeInterrupt,
	input wire logic takeException,
	input wire logic takeBreak,
	input wire logic memAck,
	input wire logic [DATA_W-1:0] memRdata,
	output logic memReq,
	output logic memWe,
	output logic [3:0] memBe,
	output logic [ADDR_W-1:0] memAddr,
	output logic [DATA_W-1:0] memWdata,
	output logic instDone,
	output logic regWe,
	output logic [4:0] regDest,
	output logic [DATA_W-1:0] regData,
	output logic carryWe,
	output logic status_carry_flag,
	output logic reserved,
	output logic [ADDR_W-1:0] reservedAddr
);
	// ----------------------------------------
	// Decode
	// ----------------------------------------
	function automatic logic isOp(input logic [31:0] w, input logic [5:0] opc,
		input logic [10:0] fn);
		isOp = (w[lrsc_pkg::OPC_HI:lrsc_pkg::OPC_LO] == opc)
			&& (w[lrsc_pkg::FN_HI:lrsc_pkg::FN_LO] == fn);
	endfunction : isOp

	logic isLoad;
	logic isStore;
	logic [ADDR_W-1:0] effAddr;
	logic [ADDR_W-1:0] sumAddr;
	assign isLoad = isOp(instWord, lrsc_pkg::OPC_LOAD, lrsc_pkg::FN_RESERVE_LOAD);
	assign isStore = isOp(instWord, lrsc_pkg::OPC_STORE, lrsc_pkg::FN_COND_STORE);
	assign sumAddr = ADDR_W'(srcA + srcB);
	// Low bits dropped: word granularity, no alignment fault path exists
	assign effAddr = {sumAddr[ADDR_W-1:$bits(lrsc_pkg::WORD_ALIGN)], lrsc_pkg::WORD_ALIGN};

	// ----------------------------------------
	// State
	// ----------------------------------------
	lrsc_pkg::lrsc_state_t state_r, state_nxt;
	logic resv_r, resv_nxt;
	logic [ADDR_W-1:0] resvAddr_r, resvAddr_nxt;
	logic memReq_r, memReq_nxt;
	logic memWe_r, memWe_nxt;
	logic [ADDR_W-1:0] memAddr_r, memAddr_nxt;
	logic [DATA_W-1:0] memWdata_r, memWdata_nxt;
	logic done_r, done_nxt;
	logic regWe_r, regWe_nxt;
	logic [4:0] regDest_r, regDest_nxt;
	logic [DATA_W-1:0] regData_r, regData_nxt;
	logic carryWe_r, carryWe_nxt;
	logic carry_r, carry_nxt;
	logic [3:0] memBe_r, memBe_nxt;
	logic clearEvent;
	logic accept;

	assign clearEvent = takeInterrupt | takeException | takeBreak;
	// Done cycle ignored: the caller still holds the finished instruction there
	assign accept = instValid && !done_r;

	always_comb begin
		state_nxt = state_r;
		resv_nxt = resv_r;
		resvAddr_nxt = resvAddr_r;
		memReq_nxt = memReq_r;
		memWe_nxt = memWe_r;
		memAddr_nxt = memAddr_r;
		memWdata_nxt = memWdata_r;
		done_nxt = 1'b0;
		regWe_nxt = 1'b0;
		regDest_nxt = regDest_r;
		regData_nxt = regData_r;
		carryWe_nxt = 1'b0;
		carry_nxt = carry_r;
		memBe_nxt = lrsc_pkg::ALL_LANES;
		case (state_r)
			lrsc_pkg::LRSC_IDLE: begin
				if (accept && isLoad) begin
					memReq_nxt = 1'b1;
					memWe_nxt = 1'b0;
					memAddr_nxt = effAddr;
					regDest_nxt = instWord[lrsc_pkg::RD_HI:lrsc_pkg::RD_LO];
					resv_nxt = 1'b1;
					resvAddr_nxt = effAddr;
					state_nxt = lrsc_pkg::LRSC_LOAD;
				end else if (accept && isStore) begin
					resv_nxt = 1'b0;
					carryWe_nxt = 1'b1;
					if (resv_r) begin
						// No address compare: any reservation allows the write
						memReq_nxt = 1'b1;
						memWe_nxt = 1'b1;
						memAddr_nxt = effAddr;
						memWdata_nxt = srcStore;
						carry_nxt = lrsc_pkg::CARRY_SUCCESS;
						state_nxt = lrsc_pkg::LRSC_STORE;
					end else begin
						carry_nxt = lrsc_pkg::CARRY_FAIL;
						done_nxt = 1'b1;
					end
				end
			end
			lrsc_pkg::LRSC_LOAD: begin
				// Read only: other masters keep free read access
				if (memAck) begin
					memReq_nxt = 1'b0;
					regWe_nxt = 1'b1;
					regData_nxt = memRdata;
					done_nxt = 1'b1;
					state_nxt = lrsc_pkg::LRSC_IDLE;
				end
			end
			lrsc_pkg::LRSC_STORE: begin
				if (memAck) begin
					memReq_nxt = 1'b0;
					memWe_nxt = 1'b0;
					done_nxt = 1'b1;
					state_nxt = lrsc_pkg::LRSC_IDLE;
				end
			end
			default: state_nxt = lrsc_pkg::LRSC_IDLE;
		endcase
		// Trap entry wins over a reserving load in the same cycle
		if (clearEvent) begin
			resv_nxt = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_r <= lrsc_pkg::LRSC_IDLE;
			resv_r <= lrsc_pkg::RESV_RESET;
			resvAddr_r <= '0;
			memReq_r <= 1'b0;
			memWe_r <= 1'b0;
			memAddr_r <= '0;
			memWdata_r <= '0;
			done_r <= 1'b0;
			regWe_r <= 1'b0;
			regDest_r <= 5'h00;
			regData_r <= '0;
			carryWe_r <= 1'b0;
			carry_r <= 1'b0;
			memBe_r <= lrsc_pkg::ALL_LANES;
		end else begin
			state_r <= state_nxt;
			resv_r <= resv_nxt;
			resvAddr_r <= resvAddr_nxt;
			memReq_r <= memReq_nxt;
			memWe_r <= memWe_nxt;
			memAddr_r <= memAddr_nxt;
			memWdata_r <= memWdata_nxt;
			done_r <= done_nxt;
			regWe_r <= regWe_nxt;
			regDest_r <= regDest_nxt;
			regData_r <= regData_nxt;
			carryWe_r <= carryWe_nxt;
			carry_r <= carry_nxt;
			memBe_r <= memBe_nxt;
		end
	end

	assign memReq = memReq_r;
	assign memWe = memWe_r;
	assign memBe = memBe_r;
	assign memAddr = memAddr_r;
	assign memWdata = memWdata_r;
	assign instDone = done_r;
	assign regWe = regWe_r;
	assign regDest = regDest_r;
	assign regData = regData_r;
	assign carryWe = carryWe_r;
	assign status_carry_flag = carry_r;
	assign reserved = resv_r;
	assign reservedAddr = resvAddr_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	idle_store_ok_a: assert property (@(posedge core_clk) disable iff (rst)
		state_r == lrsc_pkg::LRSC_IDLE && accept && isStore && resv_r
		|=> memReq && memWe && carryWe && !status_carry_flag)
		else $error("reserved conditional store did not write");
	fail_no_write_a: assert property (@(posedge core_clk) disable iff (rst)
		state_r == lrsc_pkg::LRSC_IDLE && accept && isStore && !resv_r
		|=> !memReq && status_carry_flag && carryWe && instDone)
		else $error("failed conditional store misbehaved");
	store_clears_a: assert property (@(posedge core_clk) disable iff (rst)
		state_r == lrsc_pkg::LRSC_IDLE && accept && isStore |=> !reserved)
		else $error("conditional store left reservation");
	load_sets_a: assert property (@(posedge core_clk) disable iff (rst)
		state_r == lrsc_pkg::LRSC_IDLE && accept && isLoad && !clearEvent
		|=> reserved && reservedAddr == $past(effAddr) && memReq && !memWe)
		else $error("reserving load did not reserve");
	event_clears_a: assert property (@(posedge core_clk) disable iff (rst)
		clearEvent |=> !reserved)
		else $error("trap did not clear reservation");
	addr_aligned_a: assert property (@(posedge core_clk) disable iff (rst)
		memReq |-> memAddr[1:0] == lrsc_pkg::WORD_ALIGN)
		else $error("unaligned memory address");
	load_reads_a: assert property (@(posedge core_clk) disable iff (rst)
		state_r == lrsc_pkg::LRSC_LOAD |-> !memWe)
		else $error("reserving load wrote memory");
	load_returns_a: assert property (@(posedge core_clk) disable iff (rst)
		state_r == lrsc_pkg::LRSC_LOAD && memAck
		|=> regWe && instDone && regData == $past(memRdata) ##1 !regWe)
		else $error("loaded word not returned");
	resv_set_only_a: assert property (@(posedge core_clk) disable iff (rst)
		!$past(reserved) && reserved |-> $past(instValid && isLoad))
		else $error("reservation set without load");
	cov_pair_c: cover property (@(posedge core_clk) disable iff (rst)
		reserved ##[1:20] (carryWe && !status_carry_flag));
	cov_fail_c: cover property (@(posedge core_clk) disable iff (rst)
		carryWe && status_carry_flag);
	cov_trap_c: cover property (@(posedge core_clk) disable iff (rst)
		reserved && clearEvent);
endmodule : lrsc_reservation

// *** testbench/lrsc_mem_model.sv ***
// Data memory model behind the reservation block.
// Assumes each request is held until the cycle after memAck.
`timescale 1ns/1ps
module lrsc_mem_model (
	input wire logic core_clk,
	input wire logic [3:0] delay,
	input wire logic memReq,
	input wire logic memWe,
	input wire logic [31:0] memAddr,
	input wire logic [31:0] memWdata,
	output logic memAck,
	output logic [31:0] memRdata
);
	logic [31:0] mem [16];
	int cnt = 0;
	initial begin
		memAck = 1'b0;
		memRdata = 32'h0;
		for (int i = 0; i < 16; i++) mem[i] = 32'hC0DE0000 + 32'(i);
	end
	always @(posedge core_clk) begin
		// Toggled so stale data never looks valid
		memRdata <= ~memRdata;
		memAck <= 1'b0;
		if (memReq && !memAck) begin
			if (cnt < int'(delay)) cnt <= cnt + 1;
			else begin
				cnt <= 0;
				memAck <= 1'b1;
				memRdata <= mem[memAddr[5:2]];
				if (memWe) mem[memAddr[5:2]] <= memWdata;
			end
		end
	end
endmodule : lrsc_mem_model

// *** testbench/lrsc_reservation_test.sv ***
// Self-checking bench for the reservation block.
// Assumes the memory model is compiled first.
`timescale 1ns/1ps
module lrsc_reservation_test;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic instValid = 1'b0;
	logic [31:0] instWord = 32'h0;
	logic [31:0] srcA = 32'h0;
	logic [31:0] srcB = 32'h0;
	logic [31:0] srcStore = 32'h0;
	logic [2:0] take = 3'h0;
	logic [3:0] delay = 4'h0;
	logic memAck, memReq, memWe, instDone, regWe, carryWe, carry, reserved, sawReq;
	logic sawCarry, sawWe;
	logic [3:0] memBe;
	logic [4:0] regDest;
	logic [31:0] memRdata, memAddr, memWdata, regData, reservedAddr, reqAddr, loadData;
	int numErrors = 0;
	int testsRun = 0;
	int cycles = 0;
	lrsc_reservation i_lrsc_reservation (.core_clk(core_clk), .rst(rst),
		.instValid(instValid), .instWord(instWord), .srcA(srcA), .srcB(srcB),
		.srcStore(srcStore), .takeInterrupt(take[0]), .takeException(take[1]),
		.takeBreak(take[2]), .memAck(memAck), .memRdata(memRdata), .memReq(memReq),
		.memWe(memWe), .memBe(memBe), .memAddr(memAddr), .memWdata(memWdata),
		.instDone(instDone), .regWe(regWe), .regDest(regDest), .regData(regData),
		.carryWe(carryWe), .status_carry_flag(carry), .reserved(reserved),
		.reservedAddr(reservedAddr));
	lrsc_mem_model i_lrsc_mem_model (.core_clk(core_clk), .delay(delay), .memReq(memReq),
		.memWe(memWe), .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck),
		.memRdata(memRdata));
	initial begin
		forever #50 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			numErrors++;
			final_report();
		end
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		testsRun++;
		if (got !== exp) begin
			numErrors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// Waits a bounded time for instDone; unknown opcodes never finish
	task automatic exec(input logic [5:0] op, input logic [10:0] fn, input logic [31:0] a,
		input logic [31:0] b, input logic [31:0] d);
		int n;
		n = 0;
		sawReq = 1'b0;
		sawCarry = 1'b0;
		sawWe = 1'b0;
		reqAddr = 32'h0;
		loadData = 32'h0;
		@(posedge core_clk);
		instValid <= 1'b1;
		instWord <= {op, 5'h03, 10'h000, fn};
		srcA <= a;
		srcB <= b;
		srcStore <= d;
		do begin
			@(posedge core_clk);
			n++;
			if (memReq === 1'b1) begin
				sawReq = 1'b1;
				sawWe = memWe;
				reqAddr = memAddr;
			end
			if (carryWe === 1'b1) sawCarry = 1'b1;
			if (regWe === 1'b1) loadData = regData;
		end while (instDone !== 1'b1 && n < 12);
		instValid <= 1'b0;
		@(posedge core_clk);
	endtask : exec
	task automatic load(input logic [31:0] a, input logic [31:0] b, input logic [31:0] exp);
		exec(lrsc_pkg::OPC_LOAD, lrsc_pkg::FN_RESERVE_LOAD, a, b, 32'h0);
		chk("loadData", exp, loadData);
		chk("reserved", 32'h1, 32'(reserved));
		chk("reservedAddr", (a + b) & 32'hFFFFFFFC, reservedAddr);
		chk("reqAddr", (a + b) & 32'hFFFFFFFC, reqAddr);
		chk("regDest", 32'h3, 32'(regDest));
		chk("loadCarryWe", 32'h0, 32'(sawCarry));
		chk("loadWe", 32'h0, 32'(sawWe));
	endtask : load
	task automatic store(input logic [31:0] a, input logic ok);
		exec(lrsc_pkg::OPC_STORE, lrsc_pkg::FN_COND_STORE, a, 32'h0, 32'h12345678);
		chk("sawReq", 32'(ok), 32'(sawReq));
		chk("carry", 32'(!ok), 32'(carry));
		chk("carryWe", 32'h1, 32'(sawCarry));
		chk("storeWe", 32'(ok), 32'(sawWe));
		chk("reserved", 32'h0, 32'(reserved));
	endtask : store
	task automatic final_report();
		if (numErrors == 0 && testsRun > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : final_report
	initial begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		chk("resetResv", 32'h0, 32'(reserved));
		chk("memBe", 32'hF, 32'(memBe));
		load(32'hC, 32'h4, 32'hC0DE0004);
		load(32'h20, 32'h3, 32'hC0DE0008);
		store(32'h30, 1'b1);
		store(32'h20, 1'b0);
		delay <= 4'h3;
		load(32'h30, 32'h0, 32'h12345678);
		load(32'h20, 32'h0, 32'hC0DE0008);
		exec(lrsc_pkg::OPC_STORE, 11'h0, 32'h8, 32'h0, 32'h0);
		chk("plainStore", 32'h0, 32'(sawReq));
		chk("plainCarry", 32'h0, 32'(sawCarry));
		for (int k = 0; k < 3; k++) begin
			load(32'h10, 32'h0, 32'hC0DE0004);
			take <= 3'h1 << k;
			@(posedge core_clk);
			take <= 3'h0;
			store(32'h10, 1'b0);
		end
		load(32'h10, 32'h0, 32'hC0DE0004);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		chk("midReset", 32'h0, 32'(reserved));
		final_report();
	end
endmodule : lrsc_reservation_test
